// ---- src/psc_pkg.sv ----
/*
 * constants and types of the parallel slave port control block.
 * assumes a wishbone classic slave with 32-bit data, byte addressed.
 */
`default_nettype none

package psc_pkg;

    // ***************************************************************
    // register indices; byte address is four times the index
    // ***************************************************************
    localparam logic [7:0] IDX_DATA_PORT   = 8'h08;
    localparam logic [7:0] IDX_CTL_PORT    = 8'h09;
    localparam logic [7:0] IDX_IRQ_FLAG    = 8'h0c;
    localparam logic [7:0] IDX_DATA_DIR    = 8'h88;
    localparam logic [7:0] IDX_CTL_DIRSTAT = 8'h89;
    localparam logic [7:0] IDX_IRQ_ENABLE  = 8'h8c;
    localparam logic [7:0] IDX_ANALOG_CFG  = 8'h9f;

    // ***************************************************************
    // field positions
    // ***************************************************************
    localparam int POS_READ_STROBE  = 0;
    localparam int POS_WRITE_STROBE = 1;
    localparam int POS_SELECT       = 2;
    localparam int POS_IRQ_BIT      = 7;
    localparam int POS_OVF_BIT      = 5;

    // ***************************************************************
    // reset values
    // ***************************************************************
    localparam logic [7:0] RST_CTL_DIRSTAT = 8'h07;
    localparam logic [2:0] RST_ANALOG_CFG  = 3'h0;
    localparam logic [2:0] RST_CTL_LATCH   = 3'h0;
    localparam logic [7:0] RST_DATA_DIR    = 8'hff;
    localparam logic [7:0] RST_DATA_LATCH  = 8'h00;
    localparam logic [2:0] RST_CTL_SYNC    = 3'h7;
    localparam logic [7:0] RST_DATA_SYNC   = 8'h00;

    // analog config making all control pins digital
    localparam logic [2:0] CFG_ALL_DIGITAL = 3'h7;

    // ***************************************************************
    // types
    // ***************************************************************
    typedef struct packed {
        logic       inputFull;
        logic       outputFull;
        logic       inputOverflow;
        logic       slaveModeEnable;
        logic       unused3;
        logic [2:0] ctlDir;
    } psc_dirstat_t;

endpackage

`default_nettype wire

// ---- src/psc_sync.sv ----
/*
 * three-stage synchroniser; output follows when stages two and
 * three agree. assumes inputs asynchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none

module psc_sync #(
    parameter int         W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);

    logic [W-1:0] s1Q;
    logic [W-1:0] s2Q;
    logic [W-1:0] s3Q;
    wire  [W-1:0] agree = ~(s2Q ^ s3Q);
    wire  [W-1:0] qD    = (agree & s3Q) | (~agree & q);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1Q <= RST_VAL;
            s2Q <= RST_VAL;
            s3Q <= RST_VAL;
            q   <= RST_VAL;
        end else begin
            s1Q <= d;
            s2Q <= s1Q;
            s3Q <= s2Q;
            q   <= qD;
        end
    end

endmodule // psc_sync

`default_nettype wire

// ---- src/psc_top.sv ----
/*
 * parallel slave port control: three control pins, eight data pins,
 * direction and status registers, wishbone classic register slave.
 * assumes core_clk at 250 MHz, rst is the power-up/brown-out reset,
 * otherRst a synchronous pulse from the reset-pin or watchdog logic.
 */
// Summary of operation
// RULE_01 - read strobe and select low drive the output latch.
// RULE_02 - write strobe and select low capture the input latch.
// RULE_03 - select is active low; when high, strobes are ignored.
// RULE_04 - control pins are digital io, strobes, or analog.
// RULE_05 - 28-pin build: no data or control ports, read zero.
// RULE_06 - 28-pin build: software keeps irq enable and flag clear.
// RULE_07 - unimplemented bits ignore writes and read as zero.
// RULE_08 - power-up reset loads direction/status 0000 -111.
// RULE_09 - other resets follow their column; port latch kept.
// RULE_10 - slave mode needs control pins as digital inputs.
// RULE_11 - write release latches data; flags set a cycle later.
// RULE_12 - write while input full sets overflow; clear after read.
// RULE_13 - read start clears output full; release stops drive.
// RULE_14 - strobes and select pass a synchroniser.
`timescale 1ns/1ps
`default_nettype none

module psc_top #(
    parameter bit PIN28  = 1'b0,
    parameter int ADDR_W = 12
) (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              otherRst,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output var  logic [31:0]       wb_dat_o,
    output var  logic              wb_ack_o,
    input  wire logic [2:0]        ctlPinIn,
    output var  logic [2:0]        ctlPinOut,
    output var  logic [2:0]        ctlPinOe,
    output var  logic [2:0]        ctlPinAnalog,
    input  wire logic [7:0]        dataPinIn,
    output var  logic [7:0]        dataPinOut,
    output var  logic [7:0]        dataPinOe,
    output var  logic              slaveIrqFlag
);

    // ***************************************************************
    // input synchronisers
    // ***************************************************************
    logic [2:0] ctlSync;
    logic [7:0] dataSync;

    psc_sync #(
        .W       (3),
        .RST_VAL (psc_pkg::RST_CTL_SYNC)
    ) u_ctl_sync (
        .clk (core_clk),
        .rst (rst),
        .d   (ctlPinIn),
        .q   (ctlSync)
    ); // RULE_14

    psc_sync #(
        .W       (8),
        .RST_VAL (psc_pkg::RST_DATA_SYNC)
    ) u_data_sync (
        .clk (core_clk),
        .rst (rst),
        .d   (dataPinIn),
        .q   (dataSync)
    );

    // ***************************************************************
    // register state
    // ***************************************************************
    psc_pkg::psc_dirstat_t dirStat_q;
    logic [2:0]            analogCfg_q;
    logic [2:0]            ctlLatch_q;
    logic [7:0]            dataDir_q;
    logic [7:0]            outLatch_q;
    logic [7:0]            inLatch_q;
    logic                  irqEnable_q;
    logic                  ovReadSeen_q;
    logic                  wrActive_q;
    logic                  rdActive_q;
    logic                  wrDone_q;
    logic                  rdDone_q;
    logic                  ovPend_q;

    // ***************************************************************
    // bus decode
    // ***************************************************************
    wire        busReq   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire        upperOk  = (wb_adr_i[ADDR_W-1:10] == '0);
    wire [7:0]  regIdx   = wb_adr_i[9:2];
    wire        busWr    = busReq & wb_we_i & wb_sel_i[0];
    wire        busRd    = busReq & ~wb_we_i;
    wire [7:0]  wrByte   = wb_dat_i[7:0];
    wire        present  = ~PIN28;

    wire selData   = upperOk & (regIdx == psc_pkg::IDX_DATA_PORT);
    wire selCtl    = upperOk & (regIdx == psc_pkg::IDX_CTL_PORT);
    wire selFlag   = upperOk & (regIdx == psc_pkg::IDX_IRQ_FLAG);
    wire selDDir   = upperOk & (regIdx == psc_pkg::IDX_DATA_DIR);
    wire selDStat  = upperOk & (regIdx == psc_pkg::IDX_CTL_DIRSTAT);
    wire selEnable = upperOk & (regIdx == psc_pkg::IDX_IRQ_ENABLE);
    wire selCfg    = upperOk & (regIdx == psc_pkg::IDX_ANALOG_CFG);

    // 28-pin build has no ports
    wire wrData   = busWr & selData & present; // RULE_05
    wire wrCtl    = busWr & selCtl & present; // RULE_05
    wire wrDDir   = busWr & selDDir & present; // RULE_05
    wire wrDStat  = busWr & selDStat & present; // RULE_05
    wire wrFlag   = busWr & selFlag;
    wire wrEnable = busWr & selEnable;
    wire wrCfg    = busWr & selCfg;
    wire rdData   = busRd & selData & present;

    // ***************************************************************
    // pin mode selection
    // ***************************************************************
    wire allDigital = (analogCfg_q == psc_pkg::CFG_ALL_DIGITAL);
    wire slaveMode  = dirStat_q.slaveModeEnable & present;
    // strobes need digital inputs
    wire strobeOk   = slaveMode & allDigital & (&dirStat_q.ctlDir); // RULE_10
    wire [2:0] ctlDigIn = allDigital ? ctlSync : 3'h0; // RULE_04

    wire selected = ~ctlSync[psc_pkg::POS_SELECT]; // RULE_03
    wire wrNow = strobeOk & selected
               & ~ctlSync[psc_pkg::POS_WRITE_STROBE]; // RULE_02
    wire rdNow = strobeOk & selected
               & ~ctlSync[psc_pkg::POS_READ_STROBE]; // RULE_01

    wire wrRelease = wrActive_q & ~wrNow;
    wire rdStart   = rdNow & ~rdActive_q;
    wire rdRelease = rdActive_q & ~rdNow;

    // ***************************************************************
    // status flag next values
    // ***************************************************************
    wire fullSet  = wrDone_q; // RULE_11
    wire fullClr  = rdData;
    wire fullD    = slaveMode & (fullSet | (dirStat_q.inputFull & ~fullClr));

    // a read start beats a same-cycle firmware write of the latch
    wire outFullD = slaveMode & ~rdStart
                  & (wrData | dirStat_q.outputFull); // RULE_13

    wire ovSet    = wrDone_q & ovPend_q; // RULE_12
    wire ovClrReq = wrDStat & ~wrByte[psc_pkg::POS_OVF_BIT];
    wire ovClr    = ovClrReq & (ovReadSeen_q | rdData); // RULE_12
    wire ovD      = ovSet | (dirStat_q.inputOverflow & ~ovClr);
    wire ovSeenD  = ~ovSet & (rdData | (ovReadSeen_q & ~ovClr));

    wire irqSet   = (wrDone_q | rdDone_q) & present; // RULE_11
    wire irqClr   = wrFlag & ~wrByte[psc_pkg::POS_IRQ_BIT];
    wire irqSetSw = wrFlag & wrByte[psc_pkg::POS_IRQ_BIT] & present;
    wire irqD     = irqSet | irqSetSw | (slaveIrqFlag & ~irqClr);

    wire modeD    = wrDStat ? wrByte[4] : dirStat_q.slaveModeEnable;
    wire [2:0] ctlDirD = wrDStat ? wrByte[2:0] : dirStat_q.ctlDir;

    // ***************************************************************
    // pin drive next values
    // ***************************************************************
    wire [7:0] dataOeD   = slaveMode ? {8{rdNow}} : ~dataDir_q; // RULE_13
    wire [7:0] dataOutD  = wrData ? wrByte : outLatch_q;
    wire [2:0] ctlOeD    = (slaveMode | ~allDigital) ? 3'h0
                         : ~dirStat_q.ctlDir; // RULE_04
    wire [2:0] ctlLatchD = wrCtl ? wrByte[2:0] : ctlLatch_q;
    wire [2:0] analogD   = present ? ~{3{allDigital}} : 3'h0;

    // ***************************************************************
    // read data selection
    // ***************************************************************
    wire [7:0] dataRd  = slaveMode ? inLatch_q : dataSync;
    wire [7:0] dStatRd = {dirStat_q.inputFull, dirStat_q.outputFull,
                          dirStat_q.inputOverflow,
                          dirStat_q.slaveModeEnable, 1'b0,
                          dirStat_q.ctlDir}; // RULE_07
    wire [7:0] rdByte  =
          (selData   & present) ? dataRd
        : (selCtl    & present) ? {5'h00, ctlDigIn}
        : (selDDir   & present) ? dataDir_q
        : (selDStat  & present) ? dStatRd
        : selFlag               ? {slaveIrqFlag, 7'h00}
        : selEnable             ? {irqEnable_q, 7'h00}
        : selCfg                ? {5'h00, analogCfg_q}
        : 8'h00; // RULE_05 RULE_07
    wire [31:0] rdWord = busRd ? {24'h000000, rdByte} : 32'h00000000;

    // ***************************************************************
    // bus answer
    // ***************************************************************
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= busReq;
            wb_dat_o <= rdWord;
        end
    end

    // ***************************************************************
    // configuration registers, reset by both reset kinds
    // ***************************************************************
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dirStat_q   <= psc_pkg::RST_CTL_DIRSTAT; // RULE_08
            analogCfg_q <= psc_pkg::RST_ANALOG_CFG; // RULE_08
            dataDir_q   <= psc_pkg::RST_DATA_DIR;
            irqEnable_q <= 1'b0;
            slaveIrqFlag <= 1'b0;
            ovReadSeen_q <= 1'b0;
        end else if (otherRst) begin
            dirStat_q   <= psc_pkg::RST_CTL_DIRSTAT; // RULE_09
            analogCfg_q <= psc_pkg::RST_ANALOG_CFG; // RULE_09
            dataDir_q   <= psc_pkg::RST_DATA_DIR;
            irqEnable_q <= 1'b0;
            slaveIrqFlag <= 1'b0;
            ovReadSeen_q <= 1'b0;
        end else begin
            dirStat_q.inputFull       <= fullD;
            dirStat_q.outputFull      <= outFullD;
            dirStat_q.inputOverflow   <= ovD;
            dirStat_q.slaveModeEnable <= modeD;
            dirStat_q.unused3         <= 1'b0;
            dirStat_q.ctlDir          <= ctlDirD;
            if (wrCfg) begin
                analogCfg_q <= wrByte[2:0];
            end
            if (wrDDir) begin
                dataDir_q <= wrByte;
            end
            if (wrEnable) begin
                irqEnable_q <= wrByte[psc_pkg::POS_IRQ_BIT] & present;
            end
            slaveIrqFlag <= irqD;
            ovReadSeen_q <= ovSeenD;
        end
    end

    // ***************************************************************
    // port latches, kept across other resets
    // ***************************************************************
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctlLatch_q <= psc_pkg::RST_CTL_LATCH;
            outLatch_q <= psc_pkg::RST_DATA_LATCH;
            inLatch_q  <= psc_pkg::RST_DATA_LATCH;
        end else begin
            ctlLatch_q <= ctlLatchD; // RULE_09
            outLatch_q <= dataOutD;
            if (wrRelease) begin
                inLatch_q <= dataSync; // RULE_11 RULE_12
            end
        end
    end

    // ***************************************************************
    // strobe tracking
    // ***************************************************************
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wrActive_q <= 1'b0;
            rdActive_q <= 1'b0;
            wrDone_q   <= 1'b0;
            rdDone_q   <= 1'b0;
            ovPend_q   <= 1'b0;
        end else begin
            wrActive_q <= wrNow;
            rdActive_q <= rdNow;
            wrDone_q   <= wrRelease; // RULE_11
            rdDone_q   <= rdRelease; // RULE_13
            ovPend_q   <= dirStat_q.inputFull & ~fullClr; // RULE_12
        end
    end

    // ***************************************************************
    // pin drivers
    // ***************************************************************
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dataPinOe    <= 8'h00;
            dataPinOut   <= 8'h00;
            ctlPinOe     <= 3'h0;
            ctlPinOut    <= 3'h0;
            ctlPinAnalog <= 3'h0;
        end else begin
            dataPinOe    <= present ? dataOeD : 8'h00; // RULE_01
            dataPinOut   <= dataOutD;
            ctlPinOe     <= present ? ctlOeD : 3'h0; // RULE_04
            ctlPinOut    <= ctlLatchD;
            ctlPinAnalog <= analogD; // RULE_04
        end
    end

endmodule // psc_top

`default_nettype wire

// ---- bench/psc_top_sva.sv ----
/* checker for psc_top: bus answer, pin drive, flag timing.
   bound to every psc_top; sees only its ports. */
`timescale 1ns/1ps
`default_nettype none

module psc_top_sva #(
    parameter bit PIN28  = 1'b0,
    parameter int ADDR_W = 12
) (
    input wire logic              core_clk,
    input wire logic              rst,
    input wire logic              otherRst,
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic              wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0]        wb_sel_i,
    input wire logic [31:0]       wb_dat_i,
    input wire logic [31:0]       wb_dat_o,
    input wire logic              wb_ack_o,
    input wire logic [2:0]        ctlPinIn,
    input wire logic [2:0]        ctlPinOut,
    input wire logic [2:0]        ctlPinOe,
    input wire logic [2:0]        ctlPinAnalog,
    input wire logic [7:0]        dataPinIn,
    input wire logic [7:0]        dataPinOut,
    input wire logic [7:0]        dataPinOe,
    input wire logic              slaveIrqFlag
);
    // ***************************************************
    // mode tracking and pin counters
    // ***************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    logic       mode_q, dirAll_q;
    logic [2:0] cfg_q;
    logic [3:0] rdCnt_q, wrCnt_q, rdIdle_q, csIdle_q, strbAge_q;
    wire [7:0] regIdx = wb_adr_i[9:2];
    wire wrHit = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o
                 & wb_sel_i[0] & (wb_adr_i[ADDR_W-1:10] == '0);
    wire slave = mode_q & dirAll_q & (cfg_q == 3'h7) & !PIN28;
    wire xfer = !ctlPinIn[2] & !(ctlPinIn[0] & ctlPinIn[1]);

    function automatic logic [3:0] inc(input logic [3:0] v);
        return v + {3'h0, v != 4'hf};
    endfunction

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst || otherRst) begin
            mode_q   <= 1'b0;
            dirAll_q <= 1'b1;
            cfg_q    <= 3'h0;
        end else if (wrHit && regIdx == psc_pkg::IDX_CTL_DIRSTAT) begin
            mode_q   <= wb_dat_i[4];
            dirAll_q <= &wb_dat_i[2:0];
        end else if (wrHit && regIdx == psc_pkg::IDX_ANALOG_CFG) begin
            cfg_q    <= wb_dat_i[2:0];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdCnt_q   <= 4'h0;
            wrCnt_q   <= 4'h0;
            rdIdle_q  <= 4'h0;
            csIdle_q  <= 4'h0;
            strbAge_q <= 4'hf;
        end else begin
            rdCnt_q   <= (ctlPinIn == 3'b010) ? inc(rdCnt_q) : 4'h0;
            wrCnt_q   <= (ctlPinIn == 3'b001) ? inc(wrCnt_q) : 4'h0;
            rdIdle_q  <= ctlPinIn[0] ? inc(rdIdle_q) : 4'h0;
            csIdle_q  <= ctlPinIn[2] ? inc(csIdle_q) : 4'h0;
            strbAge_q <= xfer ? 4'h0 : inc(strbAge_q);
        end
    end

    // ***************************************************
    // assertions
    // ***************************************************
    a_ack_next: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    a_ack_pulse: assert property (
        wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_idle_data: assert property (
        !wb_ack_o |-> wb_dat_o == 32'h0) else $error("idle data");
    a_upper_zero: assert property (
        wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper bits");
    a_reset_quiet: assert property (
        $past(rst) |-> !wb_ack_o && dataPinOe == 8'h00 && !slaveIrqFlag)
        else $error("busy after reset");
    a_read_drive: assert property (
        slave && rdCnt_q >= 4'h8 |-> dataPinOe == 8'hff)
        else $error("no read drive");
    a_write_quiet: assert property (
        slave && wrCnt_q >= 4'h8 |-> dataPinOe == 8'h00)
        else $error("write drive");
    a_desel_quiet: assert property (
        slave && $past(slave, 2) && csIdle_q >= 4'h8 |-> dataPinOe == 8'h00)
        else $error("deselect drive");
    a_read_off: assert property (
        slave && $past(slave, 2) && rdIdle_q >= 4'h8 |-> dataPinOe == 8'h00)
        else $error("drive after read");
    a_flag_cause: assert property (
        $rose(slaveIrqFlag) |-> wrHit || $past(wrHit) || strbAge_q <= 4'hc)
        else $error("flag cause");
    a_analog_sel: assert property (
        !PIN28 && !$past(rst) && !$past(rst, 2) && $stable(cfg_q)
        && $past(cfg_q, 2) == cfg_q
        |-> ctlPinAnalog == ((cfg_q == 3'h7) ? 3'h0 : 3'h7))
        else $error("analog select");

    c_read: cover property (slave && rdCnt_q >= 4'h8);
    c_write: cover property (slave && wrCnt_q >= 4'h8);
    c_flag: cover property ($rose(slaveIrqFlag));
endmodule // psc_top_sva

bind psc_top psc_top_sva #(.PIN28(PIN28), .ADDR_W(ADDR_W)) u_sva (.*);

`default_nettype wire

// ---- bench/psc_ext_master.sv ----
/* far-side bus master: strobes, select and data pins.
   assumes a synchronising device; changes after clock edges. */
`timescale 1ns/1ps
`default_nettype none

module psc_ext_master (
    input  wire logic       core_clk,
    input  wire logic [7:0] dataPinOut,
    input  wire logic [7:0] dataPinOe,
    output var  logic [2:0] ctlPinIn,
    output var  logic [7:0] dataPinIn
);
    // ***************************************************
    // one external access, len cycles low
    // ***************************************************
    initial begin
        ctlPinIn  = 3'h7;
        dataPinIn = 8'hff;
    end

    task automatic xfer(input logic rdOp, input logic sel, input int len,
                        input logic [7:0] wd, output logic [7:0] rd);
        rd = 8'h00;
        @(posedge core_clk);
        ctlPinIn <= {~sel, rdOp, ~rdOp};
        if (!rdOp) dataPinIn <= wd;
        repeat (len) @(posedge core_clk);
        if (dataPinOe === 8'hff) begin
            rd = dataPinOut;
        end
        ctlPinIn <= 3'h7;
        repeat (8) @(posedge core_clk);
        dataPinIn <= ~wd;
        repeat (4) @(posedge core_clk);
    endtask
endmodule // psc_ext_master

`default_nettype wire

// ---- bench/psc_parallel_slave_port_control_tb_top.sv ----
/* bench for psc_top and a 28-pin copy on the same bus.
   assumes the far-side model in psc_ext_master. */
`timescale 1ns/1ps
`default_nettype none

module psc_parallel_slave_port_control_tb_top;
    logic        core_clk, rst, otherRst, wbCyc, wbStb, wbWe, wbAck;
    logic [11:0] wbAdr;
    logic [3:0]  wbSel;
    logic [31:0] wbDat, wbRd, wbRd28, rdQ, rdQ28;
    logic [2:0]  ctlIn, ctlOut, ctlOe, ctlAna;
    logic [7:0]  datIn, datOut, datOe, xq;
    logic        irqFlag;
    int          fails = 0;
    int          numChecks = 0;

    psc_top dut (
        .core_clk(core_clk), .rst(rst), .otherRst(otherRst),
        .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
        .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat),
        .wb_dat_o(wbRd), .wb_ack_o(wbAck), .ctlPinIn(ctlIn),
        .ctlPinOut(ctlOut), .ctlPinOe(ctlOe), .ctlPinAnalog(ctlAna),
        .dataPinIn(datIn), .dataPinOut(datOut), .dataPinOe(datOe),
        .slaveIrqFlag(irqFlag));
    psc_top #(.PIN28(1'b1)) dut28 (
        .core_clk(core_clk), .rst(rst), .otherRst(otherRst),
        .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
        .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat),
        .wb_dat_o(wbRd28), .wb_ack_o(), .ctlPinIn(ctlIn),
        .ctlPinOut(), .ctlPinOe(), .ctlPinAnalog(), .dataPinIn(datIn),
        .dataPinOut(), .dataPinOe(), .slaveIrqFlag());
    psc_ext_master host (
        .core_clk(core_clk), .dataPinOut(datOut), .dataPinOe(datOe),
        .ctlPinIn(ctlIn), .dataPinIn(datIn));

    // ***************************************************
    // bus and compare tasks
    // ***************************************************
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        numChecks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] i,
                       input logic [7:0] d);
        int n = 0;
        @(posedge core_clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe  <= w;
        wbAdr <= {2'b00, i, 2'b00};
        wbDat <= {24'h0, d};
        do begin
            @(posedge core_clk);
            n++;
        end while (wbAck !== 1'b1 && n < 40);
        rdQ   = wbRd;
        rdQ28 = wbRd28;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        if (n >= 40) fails++;
    endtask

    task automatic rdc(input string nm, input logic [7:0] i,
                       input logic [31:0] e);
        bus(1'b0, i, 8'h00);
        chk(nm, rdQ, e);
    endtask

    // ***************************************************
    // scenarios
    // ***************************************************
    task automatic t_reset_map;
        rdc("dirstat", psc_pkg::IDX_CTL_DIRSTAT, 32'h07);
        rdc("analog", psc_pkg::IDX_ANALOG_CFG, 32'h00);
        rdc("ctl port", psc_pkg::IDX_CTL_PORT, 32'h00);
        rdc("unmapped", 8'h10, 32'h00);
        bus(1'b1, psc_pkg::IDX_CTL_DIRSTAT, 8'hff);
        rdc("dirstat ro", psc_pkg::IDX_CTL_DIRSTAT, 32'h17);
        chk("analog pins", ctlAna, 32'h7);
    endtask

    task automatic t_other_reset;
        bus(1'b1, psc_pkg::IDX_CTL_PORT, 8'h05);
        bus(1'b1, psc_pkg::IDX_DATA_DIR, 8'h0f);
        bus(1'b1, psc_pkg::IDX_ANALOG_CFG, 8'h07);
        bus(1'b1, psc_pkg::IDX_CTL_DIRSTAT, 8'h06);
        rdc("ctl pins", psc_pkg::IDX_CTL_PORT, 32'h07);
        chk("ctl oe", ctlOe, 32'h1);
        @(posedge core_clk);
        otherRst <= 1'b1;
        @(posedge core_clk);
        otherRst <= 1'b0;
        rdc("data dir", psc_pkg::IDX_DATA_DIR, 32'hff);
        rdc("dirstat", psc_pkg::IDX_CTL_DIRSTAT, 32'h07);
        rdc("analog", psc_pkg::IDX_ANALOG_CFG, 32'h00);
        chk("ctl latch", ctlOut, 32'h5);
    endtask

    task automatic t_ext_write;
        bus(1'b1, psc_pkg::IDX_ANALOG_CFG, 8'h07);
        bus(1'b1, psc_pkg::IDX_CTL_DIRSTAT, 8'h17);
        chk("analog off", ctlAna, 32'h0);
        host.xfer(1'b0, 1'b1, 8, 8'ha5, xq);
        rdc("in full", psc_pkg::IDX_CTL_DIRSTAT, 32'h97);
        chk("flag", irqFlag, 32'h1);
        host.xfer(1'b0, 1'b1, 14, 8'h3c, xq);
        rdc("overflow", psc_pkg::IDX_CTL_DIRSTAT, 32'hb7);
        rdc("in latch", psc_pkg::IDX_DATA_PORT, 32'h3c);
        rdc("after read", psc_pkg::IDX_CTL_DIRSTAT, 32'h37);
        bus(1'b1, psc_pkg::IDX_CTL_DIRSTAT, 8'h17);
        rdc("ovf clear", psc_pkg::IDX_CTL_DIRSTAT, 32'h17);
        bus(1'b1, psc_pkg::IDX_IRQ_FLAG, 8'h00);
        chk("flag clear", irqFlag, 32'h0);
    endtask

    task automatic t_ext_read;
        bus(1'b1, psc_pkg::IDX_DATA_PORT, 8'h5a);
        rdc("out full", psc_pkg::IDX_CTL_DIRSTAT, 32'h57);
        host.xfer(1'b1, 1'b1, 14, 8'h00, xq);
        chk("read byte", xq, 32'h5a);
        rdc("out empty", psc_pkg::IDX_CTL_DIRSTAT, 32'h17);
        chk("read flag", irqFlag, 32'h1);
        chk("drive off", datOe, 32'h0);
        bus(1'b1, psc_pkg::IDX_IRQ_FLAG, 8'h00);
    endtask

    task automatic t_deselect;
        host.xfer(1'b1, 1'b0, 8, 8'h00, xq);
        chk("desel read", xq, 32'h0);
        host.xfer(1'b0, 1'b0, 8, 8'h77, xq);
        rdc("desel wr", psc_pkg::IDX_CTL_DIRSTAT, 32'h17);
        chk("desel flag", irqFlag, 32'h0);
    endtask

    task automatic t_pin28;
        bus(1'b0, psc_pkg::IDX_CTL_DIRSTAT, 8'h00);
        chk("28 dirstat", rdQ28, 32'h0);
        bus(1'b0, psc_pkg::IDX_DATA_DIR, 8'h00);
        chk("28 data dir", rdQ28, 32'h0);
        bus(1'b0, psc_pkg::IDX_CTL_PORT, 8'h00);
        chk("28 ctl port", rdQ28, 32'h0);
    endtask

    task automatic end_sim;
        $display("checks %0d fails %0d", numChecks, fails);
        if (fails == 0 && numChecks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ***************************************************
    // run control
    // ***************************************************
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    initial begin
        rst      = 1'b1;
        otherRst = 1'b0;
        wbCyc    = 1'b0;
        wbStb    = 1'b0;
        wbWe     = 1'b0;
        wbAdr    = 12'h000;
        wbSel    = 4'h1;
        wbDat    = 32'h0;
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        t_reset_map();
        t_other_reset();
        t_ext_write();
        t_ext_read();
        t_deselect();
        t_pin28();
        end_sim();
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        fails++;
        end_sim();
    end
endmodule // psc_parallel_slave_port_control_tb_top

`default_nettype wire
